// ### dac_group_defs.vh
// constants for the converter group waveform/dma block
`ifndef DAC_GROUP_DEFS_VH
`define DAC_GROUP_DEFS_VH

// register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_CHAN_CFG    8'h04
`define REG_INTERVAL    8'h08
`define REG_SW_CODE     8'h0c
`define REG_STATUS      8'h10
`define REG_WAVE_LEN    8'h14
`define REG_OUT_DESC    8'h18
`define REG_IN_DESC     8'h1c
`define REG_FIFO_DATA   8'h20

// control fields
`define CTRL_WAVE_BIT   0
`define CTRL_RUN_BIT    1
`define CTRL_CHAIN_BIT  2
`define CTRL_UPD_BIT    3
`define CTRL_CLR_BIT    4

// channel config fields: enable [3:0], reference [7:4], bipolar [11:8]
`define CFG_EN_LSB      0
`define CFG_REF_LSB     4
`define CFG_BIP_LSB     8

// status fields
`define STAT_UNDER_BIT  0
`define STAT_BUSY_BIT   1
`define STAT_LEVEL_LSB  16

// counts and reset values
`define MIN_INTERVAL    24'd40
`define MAX_XFER_DW     22'h200000
`define CODE_BITS       12
`define CODE_MID        12'h800
`define CODE_ZERO       12'h000
`define CODE_FULL       12'hfff
`define DESC_WORDS      2'd3

`endif

// ### dac_group_dma.v
// converter group control: waveform fifo, descriptor dma and synchronous update
`timescale 1ns/1ps
`include "dac_group_defs.vh"
//
// Function
// RL1 - descriptors hold host address, local address, length and next pointer
// RL2 - without chaining a transfer is cut at 2M double words
// RL3 - chained lists have no size limit and may close into a ring
// RL4 - inbound and outbound channels keep separate descriptor chains
// RL5 - dma master moves samples into the fifo without per-word software
// RL6 - one group of four channels with 12-bit codes
// RL7 - all enabled channels latch then update together
// RL8 - fifo stores waveform samples, up to 8K entries
// RL9 - longer waveforms refill the fifo continuously by dma
// RL10 - waveform updates timed by on-board interval counter
// RL11 - software sets all four channels to the same mode
// RL12 - disabled channels are left out of the update
// RL13 - per-channel reference selection and polarity
// RL14 - interval and trigger mode shared by the whole group
// RL15 - unipolar straight binary, bipolar offset binary around 0800
// RL16 - each software write gives exactly one converter output
// RL17 - converter load on each falling edge of the write strobe
// RL18 - a waveform that fits is replayed from the fifo without refetch
// RL19 - update interval count is at least 40 timebase cycles
// RL20 - empty fifo at update holds outputs and sets underrun flag
module dac_group_dma #(
    parameter FIFO_DEPTH = 8192,
    parameter FIFO_AW    = 13
)(
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata_q,
    // dma master, fetch side (samples into fifo)
    output reg         dma_req_q,
    output reg  [31:0] dma_addr_q,
    input  wire        dma_ack,
    input  wire [31:0] dma_rdata,
    // converter side
    output reg  [47:0] dac_code_q,
    output reg  [3:0]  dac_ref_q,
    output reg  [3:0]  dac_bipolar_q,
    output reg         converter_write_strobe_q
);

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
reg        wave_q, run_q, chain_q;
reg [11:0] chan_cfg_q;
reg [23:0] interval_q;
reg        underrun_q;
reg [FIFO_AW:0] wave_len_q;
reg [31:0] out_desc_q;   // outbound chain head (fetch to fifo)
reg [31:0] in_desc_q;    // inbound chain head, kept separately [RL4]

function [11:0] lane;
    input [31:0] w;
    input        hi;
    begin
        lane = hi ? w[27:16] : w[11:0];
    end
endfunction

// ----------------------------------------------------------------------
// sample fifo with replay
// ----------------------------------------------------------------------
reg [11:0]        mem_q [0:FIFO_DEPTH-1];  // sample store [RL8]
reg [FIFO_AW-1:0] wr_ptr_q, rd_ptr_q, rp_base_q;
reg [FIFO_AW:0]   level_q, played_q;
wire fifo_full  = (level_q == FIFO_DEPTH[FIFO_AW:0]);
wire fifo_empty = (level_q == {(FIFO_AW+1){1'b0}});
// waveform fits: keep data, replay instead of refetch [RL18]
wire replay = (wave_len_q != {(FIFO_AW+1){1'b0}});

// ----------------------------------------------------------------------
// descriptor walker: host addr, local addr, length, next [RL1]
// ----------------------------------------------------------------------
localparam S_IDLE = 3'd0;
localparam S_DESC = 3'd1;
localparam S_DATA = 3'd2;
localparam S_DONE = 3'd3;
reg [2:0]  st_q;
reg [1:0]  didx_q;
reg [31:0] host_q, next_q;
reg [21:0] left_q;
reg [31:0] cur_desc_q;
reg        push_lo_q;

wire sw_fifo_wr = reg_wr && (reg_addr == `REG_FIFO_DATA) && !fifo_full;
wire dma_push   = (st_q == S_DATA) && dma_req_q && dma_ack;
wire pop;
wire push = dma_push || sw_fifo_wr;
// fifo level after this edge; a new dma request needs a free slot
wire [FIFO_AW:0] level_d = (push && !(pop && !replay)) ? level_q + {{FIFO_AW{1'b0}}, 1'b1}
                         : (pop && !replay && !push) ? level_q - {{FIFO_AW{1'b0}}, 1'b1}
                         : level_q;
wire room_d = (level_d != FIFO_DEPTH[FIFO_AW:0]);

always @(posedge clk_sys)
begin
    if (reset)
    begin
        st_q       <= S_IDLE;
        didx_q     <= 2'd0;
        host_q     <= 32'h0;
        next_q     <= 32'h0;
        left_q     <= 22'h0;
        cur_desc_q <= 32'h0;
        dma_req_q  <= 1'b0;
        dma_addr_q <= 32'h0;
        push_lo_q  <= 1'b0;
    end
    else
    begin
        case (st_q)
            S_IDLE:
                if (run_q && wave_q && out_desc_q != 32'h0)
                begin
                    cur_desc_q <= out_desc_q;
                    didx_q     <= 2'd0;
                    dma_addr_q <= out_desc_q;
                    dma_req_q  <= 1'b1;
                    st_q       <= S_DESC;
                end
            S_DESC:
                if (dma_ack)
                begin
                    case (didx_q)
                        2'd0: host_q <= dma_rdata;
                        2'd1: ;   // local address: the fifo port
                        2'd2: left_q <= (!chain_q && dma_rdata > {10'h0, `MAX_XFER_DW})
                                        ? `MAX_XFER_DW : dma_rdata[21:0]; // [RL2]
                        default: next_q <= dma_rdata;
                    endcase
                    if (didx_q == `DESC_WORDS)
                    begin
                        dma_addr_q <= host_q;
                        dma_req_q  <= room_d;
                        st_q       <= S_DATA;
                    end
                    else
                    begin
                        didx_q     <= didx_q + 2'd1;
                        dma_addr_q <= cur_desc_q + {28'h0, didx_q + 2'd1, 2'b00};
                    end
                end
            S_DATA:
            begin
                // a raised request waits for its ack; stall on full fifo [RL9]
                if (!dma_req_q || dma_ack)
                    dma_req_q <= room_d && !(dma_push && left_q == 22'd1) && run_q;
                if (dma_push)
                begin
                    dma_addr_q <= dma_addr_q + 32'h4;
                    left_q     <= left_q - 22'd1;
                    if (left_q == 22'd1)
                        st_q <= S_DONE;
                end
                if (!run_q && (!dma_req_q || dma_ack))
                    st_q <= S_IDLE;
            end
            S_DONE:
                // follow chain, a ring never ends [RL3]
                if (chain_q && next_q != 32'h0 && run_q)
                begin
                    cur_desc_q <= next_q;
                    dma_addr_q <= next_q;
                    didx_q     <= 2'd0;
                    dma_req_q  <= 1'b1;
                    st_q       <= S_DESC;
                end
                else if (!run_q)
                    st_q <= S_IDLE;
            default:
                st_q <= S_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------------
// update timing and converter strobe
// ----------------------------------------------------------------------
reg [23:0] tick_q;
reg        strobe_q;
wire [23:0] ival = (interval_q < `MIN_INTERVAL) ? `MIN_INTERVAL : interval_q; // [RL19]
wire due = run_q && wave_q && (tick_q == 24'd1);  // [RL10]
assign pop = due && !fifo_empty;

wire sw_code_wr = reg_wr && (reg_addr == `REG_SW_CODE) && !wave_q;
wire [3:0] en = chan_cfg_q[`CFG_EN_LSB +: 4];

always @(posedge clk_sys)
begin
    if (reset)
    begin
        tick_q     <= `MIN_INTERVAL;
        wr_ptr_q   <= {FIFO_AW{1'b0}};
        rd_ptr_q   <= {FIFO_AW{1'b0}};
        rp_base_q  <= {FIFO_AW{1'b0}};
        level_q    <= {(FIFO_AW+1){1'b0}};
        played_q   <= {(FIFO_AW+1){1'b0}};
        dac_code_q <= {4{`CODE_MID}};
        strobe_q   <= 1'b0;
        converter_write_strobe_q <= 1'b0;
    end
    else
    begin
        tick_q <= (!run_q || !wave_q || tick_q <= 24'd1) ? ival : tick_q - 24'd1;
        if (push)
        begin
            mem_q[wr_ptr_q] <= dma_push ? lane(dma_rdata, push_lo_q) : reg_wdata[11:0]; // [RL5]
            wr_ptr_q <= wr_ptr_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
        end
        // replayed samples stay resident so level only falls when streaming
        level_q <= level_d;
        if (pop)
        begin
            // one popped sample copied to every enabled channel slot, all latched together [RL7] [RL12]
            dac_code_q <= {en[3] ? mem_q[rd_ptr_q] : dac_code_q[47:36],
                           en[2] ? mem_q[rd_ptr_q] : dac_code_q[35:24],
                           en[1] ? mem_q[rd_ptr_q] : dac_code_q[23:12],
                           en[0] ? mem_q[rd_ptr_q] : dac_code_q[11:0]};
            if (replay && played_q + 1'b1 >= wave_len_q)
            begin
                rd_ptr_q <= rp_base_q;
                played_q <= {(FIFO_AW+1){1'b0}};
            end
            else
            begin
                rd_ptr_q <= rd_ptr_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
                played_q <= played_q + {{FIFO_AW{1'b0}}, 1'b1};
            end
        end
        if (sw_code_wr)
        begin
            // one write command, one output [RL16]
            case (reg_wdata[13:12])
                2'd0: if (en[0]) dac_code_q[11:0]  <= reg_wdata[11:0];
                2'd1: if (en[1]) dac_code_q[23:12] <= reg_wdata[11:0];
                2'd2: if (en[2]) dac_code_q[35:24] <= reg_wdata[11:0];
                default: if (en[3]) dac_code_q[47:36] <= reg_wdata[11:0];
            endcase
        end
        // strobe high one cycle after codes settle, falling edge loads [RL17]
        strobe_q <= pop | sw_code_wr;
        converter_write_strobe_q <= strobe_q;
    end
end

// ----------------------------------------------------------------------
// register writes and reads
// ----------------------------------------------------------------------
always @(posedge clk_sys)
begin
    if (reset)
    begin
        wave_q     <= 1'b0;
        run_q      <= 1'b0;
        chain_q    <= 1'b0;
        chan_cfg_q <= 12'h00f;
        interval_q <= `MIN_INTERVAL;
        underrun_q <= 1'b0;
        wave_len_q <= {(FIFO_AW+1){1'b0}};
        out_desc_q <= 32'h0;
        in_desc_q  <= 32'h0;
        dac_ref_q  <= 4'h0;
        dac_bipolar_q <= 4'h0;
        reg_rdata_q <= 32'h0;
    end
    else
    begin
        if (reg_wr)
        begin
            case (reg_addr)
                `REG_CTRL:
                begin
                    wave_q  <= reg_wdata[`CTRL_WAVE_BIT];
                    run_q   <= reg_wdata[`CTRL_RUN_BIT];
                    chain_q <= reg_wdata[`CTRL_CHAIN_BIT];
                end
                `REG_CHAN_CFG: chan_cfg_q <= reg_wdata[11:0];  // [RL13]
                `REG_INTERVAL: interval_q <= reg_wdata[23:0];  // [RL14]
                `REG_WAVE_LEN: wave_len_q <= reg_wdata[FIFO_AW:0];
                `REG_OUT_DESC: out_desc_q <= reg_wdata;
                `REG_IN_DESC:  in_desc_q  <= reg_wdata;
                default: ;
            endcase
        end
        dac_ref_q     <= chan_cfg_q[`CFG_REF_LSB +: 4];
        // polarity only selects the analog mapping; codes pass unchanged [RL15]
        dac_bipolar_q <= chan_cfg_q[`CFG_BIP_LSB +: 4];
        // set wins over the clear [RL20]
        if (due && fifo_empty)
            underrun_q <= 1'b1;
        else if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[`STAT_UNDER_BIT])
            underrun_q <= 1'b0;
        reg_rdata_q <= 32'h0;
        if (reg_rd)
        begin
            case (reg_addr)
                `REG_CTRL:     reg_rdata_q <= {29'h0, chain_q, run_q, wave_q};
                `REG_CHAN_CFG: reg_rdata_q <= {20'h0, chan_cfg_q};
                `REG_INTERVAL: reg_rdata_q <= {8'h0, interval_q};
                `REG_SW_CODE:  reg_rdata_q <= {20'h0, dac_code_q[11:0]};
                `REG_STATUS:   reg_rdata_q <= {{(16-FIFO_AW-1){1'b0}}, level_q, 14'h0,
                                               (st_q != S_IDLE), underrun_q};
                `REG_WAVE_LEN: reg_rdata_q <= {{(31-FIFO_AW){1'b0}}, wave_len_q};
                `REG_OUT_DESC: reg_rdata_q <= out_desc_q;
                `REG_IN_DESC:  reg_rdata_q <= in_desc_q;
                default:       reg_rdata_q <= 32'h0;
            endcase
        end
    end
end

// push_lo_q stays low: each fetched word carries one sample in bits 11:0 [RL6]

endmodule // dac_group_dma

// ### dac_group_dma_assertions.sv
// assertions on the converter group block ports
`timescale 1ns/1ps
`include "dac_group_defs.vh"
module dac_group_dma_assertions (
    // clock, reset and register port
    input logic        clk_sys,
    input logic        reset,
    input logic [7:0]  reg_addr,
    input logic [31:0] reg_wdata,
    input logic        reg_wr,
    // dma and converter side
    input logic        dma_req_q,
    input logic [31:0] dma_addr_q,
    input logic        dma_ack,
    input logic [47:0] dac_code_q,
    input logic [3:0]  dac_ref_q,
    input logic [3:0]  dac_bipolar_q,
    input logic        converter_write_strobe_q
);
    // ----
    // shadow of mode, config and strobe spacing
    // ----
    logic        wave_q;
    logic [11:0] cfg_q;
    logic [7:0]  gap_q;
    wire         stb = converter_write_strobe_q;
    wire         sw_wr = reg_wr && reg_addr == `REG_SW_CODE && !wave_q;
    wire         cfg_wr = reg_wr && reg_addr == `REG_CHAN_CFG;
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            wave_q <= 1'b0;
            cfg_q <= 12'h00f;
            gap_q <= 8'hff;
        end
        else
        begin
            if (reg_wr && reg_addr == `REG_CTRL)
                wave_q <= reg_wdata[`CTRL_WAVE_BIT];
            if (cfg_wr)
                cfg_q <= reg_wdata[11:0];
            gap_q <= stb ? 8'h00 : gap_q + {7'h0, gap_q != 8'hff};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_strobe_single: assert property ($rose(stb) |=> !stb)
        else $error("strobe too wide");
    a_code_then_strobe: assert property (!$stable(dac_code_q) |=> stb)
        else $error("codes changed without strobe");
    a_sw_strobe: assert property (sw_wr |-> ##2 stb)
        else $error("software write gave no strobe");
    a_sw_code:
        assert property (sw_wr && cfg_q[reg_wdata[13:12]] |=>
            dac_code_q[$past(reg_wdata[13:12]) * 12 +: 12] == $past(reg_wdata[11:0]))
        else $error("software code not loaded");
    a_off_channel_held:
        assert property (sw_wr && !cfg_q[reg_wdata[13:12]] |=> $stable(dac_code_q))
        else $error("disabled channel changed");
    a_cfg_to_pins:
        assert property (cfg_wr |-> ##2 dac_ref_q == cfg_q[7:4] && dac_bipolar_q == cfg_q[11:8])
        else $error("reference or polarity not applied");
    a_dma_hold:
        assert property (dma_req_q && !dma_ack |=> dma_req_q && $stable(dma_addr_q))
        else $error("dma request dropped or moved");
    a_wave_spacing: assert property (stb && wave_q |-> gap_q >= 8'd39)
        else $error("updates closer than minimum interval");
endmodule // dac_group_dma_assertions

// ### host_mem_model.sv
// host memory answering the block's dma fetches
`timescale 1ns/1ps
module host_mem_model (
    // clock and reset
    input  logic        clk_sys,
    input  logic        reset,
    // dma fetch port
    input  logic        dma_req_q,
    input  logic [31:0] dma_addr_q,
    output logic        dma_ack,
    output logic [31:0] dma_rdata
);
    logic [31:0] mem [256];
    logic [31:0] addr_log [8];
    logic [3:0]  n_q;
    logic        slow_q;
    logic [1:0]  wait_q;
    // ----
    // descriptor ring at 0x100, samples at 0x200
    // ----
    initial
    begin
        foreach (mem[i]) mem[i] = 32'h0;
        mem[8'h40] = 32'h200;
        mem[8'h42] = 32'h2;
        mem[8'h43] = 32'h100;
        mem[8'h80] = 32'h0aa;
        mem[8'h81] = 32'h0bb;
    end
    // acks alternate prompt and two cycles late; idle data toggles
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            dma_ack <= 1'b0;
            dma_rdata <= 32'h5a5a5a5a;
            n_q <= 4'h0;
            slow_q <= 1'b0;
            wait_q <= 2'h0;
        end
        else if (dma_ack)
        begin
            dma_ack <= 1'b0;
            dma_rdata <= ~dma_rdata;
            wait_q <= {slow_q, 1'b0};
            slow_q <= !slow_q;
            if (dma_req_q && n_q < 4'h8)
            begin
                addr_log[n_q[2:0]] <= dma_addr_q;
                n_q <= n_q + 4'h1;
            end
        end
        else if (wait_q != 2'h0 || !dma_req_q)
        begin
            wait_q <= wait_q - {1'b0, wait_q != 2'h0};
            dma_rdata <= ~dma_rdata;
        end
        else
        begin
            dma_ack <= 1'b1;
            dma_rdata <= mem[dma_addr_q[9:2]];
        end
    end
endmodule // host_mem_model

// ### dac_group_dma_test.sv
// self-checking bench for the converter group block
`timescale 1ns/1ps
`include "dac_group_defs.vh"
module dac_group_dma_test;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata_q, dma_addr_q, dma_rdata, st;
    logic [47:0] dac_code_q, exp_code, code;
    logic [3:0]  dac_ref_q, dac_bipolar_q;
    logic        dma_req_q, dma_ack, stb;
    int          err_count = 0;
    int          checked = 0;
    int          gap;
    always #4 clk_sys = ~clk_sys;
    dac_group_dma #(.FIFO_DEPTH(16), .FIFO_AW(4)) DUT (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .dma_req_q(dma_req_q), .dma_addr_q(dma_addr_q), .dma_ack(dma_ack),
        .dma_rdata(dma_rdata), .dac_code_q(dac_code_q), .dac_ref_q(dac_ref_q),
        .dac_bipolar_q(dac_bipolar_q), .converter_write_strobe_q(stb));
    host_mem_model HOST (.clk_sys(clk_sys), .reset(reset), .dma_req_q(dma_req_q),
        .dma_addr_q(dma_addr_q), .dma_ack(dma_ack), .dma_rdata(dma_rdata));
    task finish_test;
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task do_reset;
        reset <= 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        st = reg_rdata_q;
    endtask
    task wait_stb;
        gap = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            gap++;
            if (gap > 400)
            begin
                chk(stb, 1'b1);
                finish_test;
            end
        end while (stb !== 1'b1);
        code = dac_code_q;
    endtask
    // ----
    // scenarios
    // ----
    task t_sw;
        logic [11:0] v [4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
        for (int c = 0; c < 4; c++)
        begin
            wr(`REG_SW_CODE, {18'h0, c[1:0], v[c]});
            #1;
            exp_code[c*12 +: 12] = v[c];
            chk(dac_code_q, exp_code);
            chk(stb, 1'b0);
            @(posedge clk_sys);
            #1;
            chk(stb, 1'b1);
            @(posedge clk_sys);
            #1;
            chk(stb, 1'b0);
        end
    endtask
    task t_cfg;
        wr(`REG_CHAN_CFG, 32'ha5e);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({dac_bipolar_q, dac_ref_q}, 8'ha5);
        wr(`REG_SW_CODE, 32'h0123);
        repeat (3) @(posedge clk_sys);
        #1;
        chk(dac_code_q, exp_code);
    endtask
    task t_under;
        do_reset;
        wr(`REG_INTERVAL, 32'd40);
        wr(`REG_FIFO_DATA, 32'h321);
        wr(`REG_CTRL, 32'h3);
        wait_stb;
        repeat (100) @(posedge clk_sys);
        #1;
        chk(dac_code_q, {4{12'h321}});
        rd(`REG_STATUS);
        chk(st[0], 1'b1);
        wr(`REG_CTRL, 32'h0);
        wr(`REG_STATUS, 32'h1);
        rd(`REG_STATUS);
        chk(st[0], 1'b0);
    endtask
    task t_dma;
        logic [31:0] a [8] = '{32'h100, 32'h104, 32'h108, 32'h10c,
                               32'h200, 32'h204, 32'h100, 32'h104};
        do_reset;
        wr(`REG_INTERVAL, 32'd40);
        wr(`REG_OUT_DESC, 32'h100);
        wr(`REG_CTRL, 32'h7);
        for (int i = 0; i < 6; i++)
        begin
            wait_stb;
            chk(code, {4{i[0] ? 12'h0bb : 12'h0aa}});
        end
        for (int i = 0; i < 8; i++)
            chk(HOST.addr_log[i], a[i]);
    endtask
    task t_wave;
        do_reset;
        wr(`REG_INTERVAL, 32'd10);
        wr(`REG_WAVE_LEN, 32'd2);
        wr(`REG_FIFO_DATA, 32'h123);
        wr(`REG_FIFO_DATA, 32'h456);
        wr(`REG_CTRL, 32'h3);
        for (int i = 0; i < 5; i++)
        begin
            wait_stb;
            chk(code, {4{i[0] ? 12'h456 : 12'h123}});
            if (i > 0)
                chk(gap >= 40, 1'b1);
        end
    endtask
    initial
    begin
        do_reset;
        exp_code = {4{`CODE_MID}};
        rd(`REG_CHAN_CFG);
        chk(st, 32'h00f);
        rd(8'hfc);
        chk(st, 32'h0);
        wr(`REG_OUT_DESC, 32'h1000);
        wr(`REG_IN_DESC, 32'h2000);
        rd(`REG_OUT_DESC);
        chk(st, 32'h1000);
        rd(`REG_IN_DESC);
        chk(st, 32'h2000);
        chk(dac_code_q, exp_code);
        t_sw;
        t_cfg;
        t_under;
        t_dma;
        t_wave;
        finish_test;
    end
endmodule // dac_group_dma_test
bind dac_group_dma dac_group_dma_assertions u_chk (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .dma_req_q(dma_req_q), .dma_addr_q(dma_addr_q), .dma_ack(dma_ack),
    .dac_code_q(dac_code_q), .dac_ref_q(dac_ref_q), .dac_bipolar_q(dac_bipolar_q),
    .converter_write_strobe_q(converter_write_strobe_q));
